// ---- verilog/pors_seq.sv ----
// Power-on reset state logic with its register file and aux clock.
`timescale 1ns/10ps
`default_nettype none
`include "pors_defines.svh"
module pors_seq (
  // Clock and power-on reset.
  input wire logic clock,
  input wire logic rst_b,
  // Device pins.
  input wire logic reset_pin,
  input wire logic wake_request_n,
  output logic aux_clock_output,
  // Core status from the same clock domain.
  input wire logic suspended,
  input wire logic bus_activity,
  input wire logic [7:0] irq_events,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_proc,
  output logic [7:0] reg_rdata,
  // Control outputs to the core.
  output logic processor_hold_reset,
  output logic token_nak,
  output logic core_answers_requests,
  output logic disconnect_drive_enable,
  output logic iso_zero_send,
  output logic autovector_enable,
  output logic chip_in_reset
);

  // *****************************************************************
  // Reset synchronizer
  // *****************************************************************

  logic por_async_b;
  logic rst_meta_q;
  logic rst_sync_q;

  // Power loss and the reset pin act alike on the state.
  assign por_async_b = rst_b & ~reset_pin;

  // Assert at once, release two edges after the pin falls.
  always_ff @(posedge clock or negedge por_async_b) begin
    if (!por_async_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign chip_in_reset = ~rst_sync_q;

  // *****************************************************************
  // Wake pin synchronizer and aux clock divider
  // *****************************************************************

  logic wake_meta_q;
  logic wake_sync_q;
  logic [7:0] div_cnt_q;
  logic aux_phase_q;

  // The wake pin is sampled twice before use.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_meta_q <= 1'b1;
      wake_sync_q <= 1'b1;
    end else begin
      wake_meta_q <= wake_request_n;
      wake_sync_q <= wake_meta_q;
    end
  end

  // The divider only obeys power, never the reset pin.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 8'h00;
      aux_phase_q <= 1'b0;
    end else if (div_cnt_q == 8'(`PORS_AUX_HALF_CYC - 1)) begin
      div_cnt_q <= 8'h00;
      aux_phase_q <= ~aux_phase_q;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // *****************************************************************
  // Register state
  // *****************************************************************

  pors_pkg::pors_state_t s_q;
  pors_pkg::pors_state_t s_d;
  logic [7:0] uninit_mem [0:`PORS_UNINIT_WORDS-1];
  logic wr_uninit;
  logic [7:0] uninit_idx;
  logic aux_run;

  assign uninit_idx = reg_addr - `PORS_A_UNINIT;
  assign wr_uninit = reg_wr && (reg_addr >= `PORS_A_UNINIT) &&
                     (uninit_idx < 8'(`PORS_UNINIT_WORDS));

  // Buffers, byte counts and port data carry no reset at all.
  always_ff @(posedge clock) begin
    if (wr_uninit) begin
      uninit_mem[uninit_idx[4:0]] <= reg_wdata;
    end
  end

  // Next state: register writes, reads, event capture and arming.
  always_comb begin
    logic [2:0] ep;
    ep = reg_addr[2:0];
    s_d = s_q;
    // Hardware events set request bits; the set wins over a clear.
    if (reg_wr && reg_addr == `PORS_A_IRQ_REQ) begin
      s_d.irq_req = (s_q.irq_req & ~reg_wdata) | irq_events;
    end else begin
      s_d.irq_req = s_q.irq_req | irq_events;
    end
    // Suspend stops the aux clock; bus activity or wake restarts it.
    if (bus_activity || !wake_sync_q) begin
      s_d.aux_stopped = 1'b0;
    end else if (suspended) begin
      s_d.aux_stopped = 1'b1;
    end
    if (reg_wr) begin
      if (reg_addr == `PORS_A_PROC_CS) begin
        s_d.hold_reset = reg_wdata[`PORS_HOLD_BIT];
        if (reg_from_proc) begin
          s_d.aux_oe = reg_wdata[`PORS_OE_BIT];
        end
        // Arm every OUT endpoint in the cycle the hold clears.
        if (s_q.hold_reset && !reg_wdata[`PORS_HOLD_BIT]) begin
          for (int i = 0; i < 8; i++) begin
            s_d.out_cs[i] = `PORS_OUT_ARM_VAL;
          end
        end
      end else if (reg_addr == `PORS_A_BUS_CS) begin
        s_d.bus_cs = reg_wdata;
      end else if (reg_addr == `PORS_A_FN_ADDR) begin
        s_d.fn_addr = reg_wdata;
      end else if (reg_addr == `PORS_A_IN_VAL) begin
        s_d.in_val = reg_wdata;
      end else if (reg_addr == `PORS_A_OUT_VAL) begin
        s_d.out_val = reg_wdata;
      end else if (reg_addr == `PORS_A_ISO_IN_VAL) begin
        s_d.iso_in_val = reg_wdata;
      end else if (reg_addr == `PORS_A_ISO_OUT_VAL) begin
        s_d.iso_out_val = reg_wdata;
      end else if (reg_addr == `PORS_A_PAIRING) begin
        s_d.pairing = reg_wdata;
      end else if (reg_addr == `PORS_A_BAV) begin
        s_d.bav = reg_wdata;
      end else if (reg_addr == `PORS_A_PORT_CFG) begin
        s_d.port_cfg = reg_wdata;
      end else if (reg_addr == `PORS_A_PORT_OE) begin
        s_d.port_oe = reg_wdata;
      end else if (reg_addr == `PORS_A_IRQ_EN) begin
        s_d.irq_en = reg_wdata;
      end else if (reg_addr == `PORS_A_TOGGLE) begin
        s_d.toggle = reg_wdata;
      end else if (reg_addr == `PORS_A_CONFIG) begin
        s_d.config_val = reg_wdata;
      end else if (reg_addr == `PORS_A_ALTSET) begin
        s_d.altset = reg_wdata;
      end else if (reg_addr[7:3] == 5'(`PORS_A_IN_CS >> 3)) begin
        s_d.in_cs[ep] = reg_wdata;
      end else if (reg_addr[7:3] == 5'(`PORS_A_OUT_CS >> 3)) begin
        s_d.out_cs[ep] = reg_wdata;
      end
    end
    // Read data stands only in the cycle after the strobe.
    s_d.rdata = `PORS_ZERO8;
    if (reg_rd) begin
      if (reg_addr == `PORS_A_PROC_CS) begin
        s_d.rdata = {`PORS_REV_NUM, 2'b00, s_q.aux_oe, s_q.hold_reset};
      end else if (reg_addr == `PORS_A_BUS_CS) begin
        s_d.rdata = s_q.bus_cs;
      end else if (reg_addr == `PORS_A_FN_ADDR) begin
        s_d.rdata = s_q.fn_addr;
      end else if (reg_addr == `PORS_A_IN_VAL) begin
        s_d.rdata = s_q.in_val;
      end else if (reg_addr == `PORS_A_OUT_VAL) begin
        s_d.rdata = s_q.out_val;
      end else if (reg_addr == `PORS_A_ISO_IN_VAL) begin
        s_d.rdata = s_q.iso_in_val;
      end else if (reg_addr == `PORS_A_ISO_OUT_VAL) begin
        s_d.rdata = s_q.iso_out_val;
      end else if (reg_addr == `PORS_A_PAIRING) begin
        s_d.rdata = s_q.pairing;
      end else if (reg_addr == `PORS_A_BAV) begin
        s_d.rdata = s_q.bav;
      end else if (reg_addr == `PORS_A_PORT_CFG) begin
        s_d.rdata = s_q.port_cfg;
      end else if (reg_addr == `PORS_A_PORT_OE) begin
        s_d.rdata = s_q.port_oe;
      end else if (reg_addr == `PORS_A_IRQ_EN) begin
        s_d.rdata = s_q.irq_en;
      end else if (reg_addr == `PORS_A_IRQ_REQ) begin
        s_d.rdata = s_q.irq_req;
      end else if (reg_addr == `PORS_A_TOGGLE) begin
        s_d.rdata = s_q.toggle;
      end else if (reg_addr == `PORS_A_CONFIG) begin
        s_d.rdata = s_q.config_val;
      end else if (reg_addr == `PORS_A_ALTSET) begin
        s_d.rdata = s_q.altset;
      end else if (reg_addr[7:3] == 5'(`PORS_A_IN_CS >> 3)) begin
        s_d.rdata = s_q.in_cs[ep];
      end else if (reg_addr[7:3] == 5'(`PORS_A_OUT_CS >> 3)) begin
        s_d.rdata = s_q.out_cs[ep];
      end else if (reg_addr >= `PORS_A_UNINIT &&
                   uninit_idx < 8'(`PORS_UNINIT_WORDS)) begin
        s_d.rdata = uninit_mem[uninit_idx[4:0]];
      end
    end
  end

  // Every resettable value is loaded from its power-on default.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q.hold_reset <= 1'b1;
      s_q.aux_oe <= 1'b1;
      s_q.bus_cs <= `PORS_BUS_CS_RST;
      s_q.fn_addr <= `PORS_ZERO8;
      s_q.in_val <= `PORS_IN_VAL_RST;
      s_q.out_val <= `PORS_OUT_VAL_RST;
      s_q.iso_in_val <= `PORS_ISO_VAL_RST;
      s_q.iso_out_val <= `PORS_ISO_VAL_RST;
      s_q.pairing <= `PORS_ZERO8;
      s_q.bav <= `PORS_ZERO8;
      s_q.port_cfg <= `PORS_ZERO8;
      s_q.port_oe <= `PORS_ZERO8;
      s_q.irq_en <= `PORS_ZERO8;
      s_q.irq_req <= `PORS_ZERO8;
      s_q.toggle <= `PORS_ZERO8;
      s_q.config_val <= `PORS_ZERO8;
      s_q.altset <= `PORS_ZERO8;
      s_q.in_cs <= '0;
      s_q.out_cs <= '0;
      s_q.aux_stopped <= 1'b0;
      s_q.rdata <= `PORS_ZERO8;
    end else begin
      s_q <= s_d;
    end
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************

  // The aux clock runs in reset; later it obeys enable and suspend.
  assign aux_run = chip_in_reset |
                   (s_q.aux_oe & ~s_q.aux_stopped);
  assign aux_clock_output = aux_phase_q & aux_run;

  assign reg_rdata = s_q.rdata;
  assign processor_hold_reset = s_q.hold_reset;
  // Tokens are refused while the processor is held.
  assign token_nak = s_q.hold_reset;
  assign core_answers_requests =
    ~s_q.bus_cs[`PORS_FIRMWARE_OWNS_ENUMERATION_BIT];
  assign disconnect_drive_enable = s_q.bus_cs[`PORS_DISC_BIT];
  assign iso_zero_send = s_q.pairing[`PORS_ISO_ZERO_BIT];
  assign autovector_enable = s_q.bav[`PORS_AUTOVEC_BIT];

  // *****************************************************************
  // Assertions
  // *****************************************************************

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  pin_resets_chip_a: assert property (
    $rose(reset_pin) |=> chip_in_reset && processor_hold_reset)
    else $error("Reset pin did not reset the chip.");

  sync_release_a: assert property (
    $fell(reset_pin) ##0 !reset_pin [*2] |-> chip_in_reset)
    else $error("Reset released too early.");

  aux_runs_reset_a: assert property (
    chip_in_reset && $changed(aux_phase_q) |-> aux_clock_output == aux_phase_q)
    else $error("Aux clock silent during reset.");

  aux_oe_silence_a: assert property (
    !chip_in_reset && !s_q.aux_oe |-> !aux_clock_output)
    else $error("Aux clock active while disabled.");

  host_keeps_oe_a: assert property (
    reg_wr && !reg_from_proc && reg_addr == `PORS_A_PROC_CS
      |=> s_q.aux_oe == $past(s_q.aux_oe))
    else $error("Host write changed aux clock enable.");

  release_arms_a: assert property (
    $fell(processor_hold_reset) |-> s_q.out_cs[3] == `PORS_OUT_ARM_VAL &&
      s_q.out_cs[0] == `PORS_OUT_ARM_VAL)
    else $error("OUT endpoints not armed on release.");

  release_write_a: assert property (
    reg_wr && reg_addr == `PORS_A_PROC_CS && reg_wdata == 8'h00
      |=> !processor_hold_reset && !token_nak)
    else $error("Zero write did not release processor.");

  reset_defaults_a: assert property (
    $rose(rst_sync_q) |-> s_q.bus_cs == `PORS_BUS_CS_RST &&
      s_q.in_val == `PORS_IN_VAL_RST && s_q.out_val == `PORS_OUT_VAL_RST &&
      core_answers_requests && disconnect_drive_enable)
    else $error("Reset defaults not loaded.");

  irq_set_wins_a: assert property (
    !chip_in_reset && irq_events != 8'h00
      |=> (s_q.irq_req & $past(irq_events)) == $past(irq_events))
    else $error("Interrupt event lost against a clear.");

  read_latency_a: assert property (
    reg_rd && reg_addr == `PORS_A_PROC_CS
      |=> reg_rdata[7:2] == {`PORS_REV_NUM, 2'b00})
    else $error("Processor status read wrong.");

  reset_hold_a: assert property (
    chip_in_reset |-> processor_hold_reset && token_nak &&
      reg_rdata == 8'h00)
    else $error("Processor not held during chip reset.");

  reset_outputs_a: assert property (
    chip_in_reset |-> core_answers_requests && disconnect_drive_enable &&
      !iso_zero_send && !autovector_enable)
    else $error("Control outputs wrong during chip reset.");

  reset_zero_regs_a: assert property (
    chip_in_reset |-> s_q.port_cfg == 8'h00 && s_q.port_oe == 8'h00 &&
      s_q.irq_en == 8'h00 && s_q.irq_req == 8'h00 &&
      s_q.toggle == 8'h00 && s_q.fn_addr == 8'h00 &&
      s_q.config_val == 8'h00 && s_q.altset == 8'h00)
    else $error("Cleared registers not zero during chip reset.");

  reset_endpoints_a: assert property (
    chip_in_reset |-> s_q.in_cs == '0 && s_q.out_cs == '0 &&
      s_q.in_val == `PORS_IN_VAL_RST &&
      s_q.out_val == `PORS_OUT_VAL_RST &&
      s_q.iso_in_val == `PORS_ISO_VAL_RST &&
      s_q.iso_out_val == `PORS_ISO_VAL_RST)
    else $error("Endpoint state wrong during chip reset.");

  aux_stop_a: assert property (
    suspended && !bus_activity && wake_sync_q && !chip_in_reset
      |=> s_q.aux_stopped || chip_in_reset)
    else $error("Suspend did not stop the aux clock.");

  aux_wake_a: assert property (
    (bus_activity || !wake_sync_q) |=> !s_q.aux_stopped)
    else $error("Wake or activity did not restart the aux clock.");

  read_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data stands outside its cycle.");

  proc_sets_oe_a: assert property (
    reg_wr && reg_from_proc && reg_addr == `PORS_A_PROC_CS && !chip_in_reset
      |=> s_q.aux_oe == $past(reg_wdata[`PORS_OE_BIT]))
    else $error("Processor write did not set aux clock enable.");

endmodule : pors_seq
`default_nettype wire

// ---- shared/pors_defines.svh ----
// Constants of the power-on reset state logic: offsets, fields, resets.
// *****************************************************************
// *****************************************************************
`ifndef PORS_DEFINES_SVH
`define PORS_DEFINES_SVH
`define PORS_A_PROC_CS 8'h00
`define PORS_A_BUS_CS 8'h01
`define PORS_A_FN_ADDR 8'h02
`define PORS_A_IN_VAL 8'h03
`define PORS_A_OUT_VAL 8'h04
`define PORS_A_ISO_IN_VAL 8'h05
`define PORS_A_ISO_OUT_VAL 8'h06
`define PORS_A_PAIRING 8'h07
`define PORS_A_BAV 8'h08
`define PORS_A_PORT_CFG 8'h09
`define PORS_A_PORT_OE 8'h0A
`define PORS_A_IRQ_EN 8'h0B
`define PORS_A_IRQ_REQ 8'h0C
`define PORS_A_TOGGLE 8'h0D
`define PORS_A_CONFIG 8'h0E
`define PORS_A_ALTSET 8'h0F
`define PORS_A_IN_CS 8'h10
`define PORS_A_OUT_CS 8'h18
`define PORS_A_UNINIT 8'h20
`define PORS_UNINIT_WORDS 17
`define PORS_REV_NUM 4'h1
`define PORS_PROC_CS_RST 4'h3
`define PORS_HOLD_BIT 0
`define PORS_OE_BIT 1
`define PORS_BUS_CS_RST 8'h04
`define PORS_FIRMWARE_OWNS_ENUMERATION_BIT 1
`define PORS_DISC_BIT 2
`define PORS_IN_VAL_RST 8'h57
`define PORS_OUT_VAL_RST 8'h55
`define PORS_ISO_VAL_RST 8'h07
`define PORS_OUT_ARM_VAL 8'h02
`define PORS_ISO_ZERO_BIT 7
`define PORS_AUTOVEC_BIT 0
`define PORS_ZERO8 8'h00
`define PORS_CLK_NS 8
`define PORS_AUX_HALF_NS 21
`define PORS_AUX_HALF_CYC ((`PORS_AUX_HALF_NS / `PORS_CLK_NS) > 0 ? \
  (`PORS_AUX_HALF_NS / `PORS_CLK_NS) : 1)
`endif

// ---- shared/pors_pkg.sv ----
// Types of the power-on reset state logic.
package pors_pkg;
  typedef logic [7:0] pors_byte_t;
  // All state of the sequencer that the synchronized reset loads with its defaults.
  typedef struct packed {
    logic hold_reset;
    logic aux_oe;
    pors_byte_t bus_cs;
    pors_byte_t fn_addr;
    pors_byte_t in_val;
    pors_byte_t out_val;
    pors_byte_t iso_in_val;
    pors_byte_t iso_out_val;
    pors_byte_t pairing;
    pors_byte_t bav;
    pors_byte_t port_cfg;
    pors_byte_t port_oe;
    pors_byte_t irq_en;
    pors_byte_t irq_req;
    pors_byte_t toggle;
    pors_byte_t config_val;
    pors_byte_t altset;
    logic [7:0][7:0] in_cs;
    logic [7:0][7:0] out_cs;
    logic aux_stopped;
    pors_byte_t rdata;
  } pors_state_t;
endpackage : pors_pkg

// ---- dv/pors_reset_driver.sv ----
// Model of the external logic that pulls the chip reset pin high.
`timescale 1ns/10ps
`default_nettype none
module pors_reset_driver (
  // Clock that times the pulse.
  input wire logic clock,
  // Pulse request and its length in cycles.
  input wire logic start,
  input wire logic [7:0] hold_cycles,
  // Chip reset pin, active high.
  output logic reset_pin
);
  logic [7:0] left_q = 8'h00;
  // Counts down the cycles for which the pin stays high.
  always @(posedge clock) begin
    if (start) begin
      left_q <= hold_cycles;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Outside a pulse the driver holds the pin low.
  assign reset_pin = (left_q != 8'h00);
endmodule : pors_reset_driver
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench of the power-on reset state logic.
`timescale 1ns/10ps
`default_nettype none
`include "pors_defines.svh"
module tb;
  // Stimulus, observed outputs and score counters.
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wake_request_n = 1'b1;
  logic suspended = 1'b0;
  logic bus_activity = 1'b0;
  logic [7:0] irq_events = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_from_proc = 1'b0;
  logic pin_start = 1'b0;
  logic reset_pin;
  logic aux_clock_output;
  logic [7:0] reg_rdata;
  logic processor_hold_reset;
  logic token_nak;
  logic core_answers_requests;
  logic disconnect_drive_enable;
  logic iso_zero_send;
  logic autovector_enable;
  logic chip_in_reset;
  logic [7:0] rd_val;
  int toggles;
  int bad_count = 0;
  int cmp_count = 0;

  // The 125 MHz clock.
  always #4 clock = ~clock;

  // Design under test and the reset pin driver.
  pors_seq pors_seq_inst (.clock(clock), .rst_b(rst_b),
    .reset_pin(reset_pin), .wake_request_n(wake_request_n),
    .aux_clock_output(aux_clock_output), .suspended(suspended),
    .bus_activity(bus_activity), .irq_events(irq_events),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_from_proc(reg_from_proc),
    .reg_rdata(reg_rdata), .processor_hold_reset(processor_hold_reset),
    .token_nak(token_nak), .core_answers_requests(core_answers_requests),
    .disconnect_drive_enable(disconnect_drive_enable),
    .iso_zero_send(iso_zero_send), .autovector_enable(autovector_enable),
    .chip_in_reset(chip_in_reset));
  pors_reset_driver pors_reset_driver_inst (.clock(clock),
    .start(pin_start), .hold_cycles(8'h0A), .reset_pin(reset_pin));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task final_report;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task check8(input logic [7:0] got, input logic [7:0] exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : check8

  task check1(input logic got, input logic exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, w, got, exp);
    end
  endtask : check1

  // Host or processor write: one cycle of strobe.
  task reg_write(input logic [7:0] a, input logic [7:0] d, input logic p);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_from_proc <= p;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read: data are taken in the single cycle after the strobe.
  task check_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check8(reg_rdata, exp, $sformatf("reg %h", a));
  endtask : check_reg

  // Waits, bounded, for the internal reset to end.
  task wait_ready;
    int n;
    n = 0;
    while (chip_in_reset !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) begin
      bad_count++;
      $display("[FAIL] %0t internal reset never ended", $time);
      final_report();
    end else begin
      repeat (2) @(posedge clock);
    end
  endtask : wait_ready

  // Counts level changes of the aux clock over some cycles.
  task count_aux(input int cycles);
    logic prev;
    @(posedge clock);
    #1;
    prev = aux_clock_output;
    toggles = 0;
    repeat (cycles) begin
      @(posedge clock);
      #1;
      if (aux_clock_output !== prev) toggles++;
      prev = aux_clock_output;
    end
  endtask : count_aux

  // Checks the state after reset, before or after processor release.
  task check_defaults(input logic arm);
    check1(processor_hold_reset, !arm, "hold");
    check1(token_nak, !arm, "nak");
    check1(core_answers_requests, 1'b1, "core answers");
    check1(disconnect_drive_enable, 1'b1, "disc");
    check1(iso_zero_send, 1'b0, "iso zero");
    check1(autovector_enable, 1'b0, "autovec");
    check_reg(`PORS_A_PROC_CS, {`PORS_REV_NUM, 3'h1, !arm});
    check_reg(`PORS_A_BUS_CS, 8'h04);
    check_reg(`PORS_A_FN_ADDR, 8'h00);
    check_reg(`PORS_A_IN_VAL, 8'h57);
    check_reg(`PORS_A_OUT_VAL, 8'h55);
    check_reg(`PORS_A_ISO_IN_VAL, 8'h07);
    check_reg(`PORS_A_ISO_OUT_VAL, 8'h07);
    check_reg(`PORS_A_PAIRING, 8'h00);
    check_reg(`PORS_A_BAV, 8'h00);
    check_reg(`PORS_A_PORT_CFG, 8'h00);
    check_reg(`PORS_A_PORT_OE, 8'h00);
    check_reg(`PORS_A_IRQ_EN, 8'h00);
    check_reg(`PORS_A_IRQ_REQ, 8'h00);
    check_reg(`PORS_A_TOGGLE, 8'h00);
    check_reg(`PORS_A_CONFIG, 8'h00);
    check_reg(`PORS_A_ALTSET, 8'h00);
    for (int i = 0; i < 8; i++) begin
      check_reg(`PORS_A_IN_CS + 8'(i), 8'h00);
      check_reg(`PORS_A_OUT_CS + 8'(i), arm ? 8'h02 : 8'h00);
    end
  endtask : check_defaults

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    wait_ready();
    check_defaults(1'b0);
    check_reg(8'h40, 8'h00);
    // Host release: arming lands with the release, clock stays on.
    reg_write(`PORS_A_PROC_CS, 8'h00, 1'b0);
    #1;
    check1(token_nak, 1'b0, "nak after release");
    check_defaults(1'b1);
    count_aux(40);
    check1(toggles >= 8, 1'b1, "aux after host write");
    // Move every register away from its default before the pin reset.
    for (int a = 1; a < 32; a++) begin
      reg_write(8'(a), 8'hFF, 1'b0);
    end
    reg_write(`PORS_A_BUS_CS, 8'h06, 1'b0);
    reg_write(`PORS_A_PAIRING, 8'h80, 1'b0);
    reg_write(`PORS_A_BAV, 8'h01, 1'b0);
    reg_write(`PORS_A_FN_ADDR, 8'h5A, 1'b0);
    reg_write(`PORS_A_UNINIT, 8'hA5, 1'b0);
    // An event and a clear of the same request bit: the event wins.
    irq_events <= 8'h01;
    reg_write(`PORS_A_IRQ_REQ, 8'h01, 1'b0);
    irq_events <= 8'h00;
    #1;
    check1(core_answers_requests, 1'b0, "firmware owns");
    check1(iso_zero_send, 1'b1, "iso zero set");
    check1(autovector_enable, 1'b1, "autovec set");
    check_reg(`PORS_A_IRQ_REQ, 8'h01);
    check_reg(`PORS_A_FN_ADDR, 8'h5A);
    check_reg(`PORS_A_TOGGLE, 8'hFF);
    reg_write(`PORS_A_PROC_CS, 8'h00, 1'b1);
    count_aux(20);
    check1(toggles == 0, 1'b1, "aux silenced");
    // Pin reset: aux clock runs and all defaults return.
    @(posedge clock);
    pin_start <= 1'b1;
    @(posedge clock);
    pin_start <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check1(chip_in_reset, 1'b1, "pin reset");
    count_aux(4);
    check1(toggles >= 1, 1'b1, "aux in reset");
    wait_ready();
    check_defaults(1'b0);
    check_reg(`PORS_A_UNINIT, 8'hA5);
    // Suspend stops the aux clock; wake and bus activity restart it.
    @(posedge clock);
    suspended <= 1'b1;
    repeat (2) @(posedge clock);
    suspended <= 1'b0;
    repeat (4) @(posedge clock);
    count_aux(20);
    check1(toggles == 0, 1'b1, "aux in suspend");
    @(posedge clock);
    wake_request_n <= 1'b0;
    repeat (4) @(posedge clock);
    wake_request_n <= 1'b1;
    count_aux(20);
    check1(toggles >= 4, 1'b1, "aux after wake");
    @(posedge clock);
    suspended <= 1'b1;
    repeat (2) @(posedge clock);
    suspended <= 1'b0;
    count_aux(10);
    check1(toggles == 0, 1'b1, "aux in second suspend");
    @(posedge clock);
    bus_activity <= 1'b1;
    @(posedge clock);
    bus_activity <= 1'b0;
    count_aux(20);
    check1(toggles >= 4, 1'b1, "aux after activity");
    final_report();
  end
endmodule : tb
`default_nettype wire
